// ===== include/crf_pkg.sv
// Package for the banked processor register file: widths, status bit
// positions, reset values, access classes and the request/response carriers.
// Assumes a single core clock shared with the decode and execute pipeline.

package crf_pkg;

  // ---------------------------------------------------------------------------
  // Widths and physical register layout
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned GR_NUM = 16;
  localparam int unsigned GR_IDX_W = 4;
  localparam int unsigned BANKED_NUM = 8;
  localparam int unsigned PHYS_NUM = 24;
  localparam int unsigned PHYS_W = 5;
  localparam logic [GR_IDX_W-1:0] INDEX_REG = 4'h0;

  // ---------------------------------------------------------------------------
  // Status word fields
  // ---------------------------------------------------------------------------
  localparam int unsigned SR_MD_POS = 30;
  localparam int unsigned SR_RB_POS = 29;
  localparam int unsigned SR_BL_POS = 28;
  localparam int unsigned SR_IMASK_LSB = 4;
  localparam int unsigned SR_IMASK_W = 4;
  localparam logic [WORD_W-1:0] SR_WRITE_MASK = 32'h7000_83f3;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [WORD_W-1:0] SR_RESET = 32'h7000_00f0;
  localparam logic [WORD_W-1:0] VBR_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] PC_RESET = 32'h0a00_0000;

  // ---------------------------------------------------------------------------
  // Access classes and register selects
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    CRF_OP_IDLE,
    CRF_OP_GR_WRITE,
    CRF_OP_LOAD_SYS,
    CRF_OP_STORE_SYS,
    CRF_OP_LOAD_CTL,
    CRF_OP_STORE_CTL,
    CRF_OP_LOAD_BANK,
    CRF_OP_STORE_BANK,
    CRF_OP_RETURN_EXC
  } crf_op_t;

  typedef enum logic [3:0] {
    CRF_SEL_MAC_HIGH,
    CRF_SEL_MAC_LOW,
    CRF_SEL_PROC_RET,
    CRF_SEL_PC,
    CRF_SEL_STATUS,
    CRF_SEL_SAVED_STATUS,
    CRF_SEL_SAVED_PC,
    CRF_SEL_GLOBAL_BASE,
    CRF_SEL_VECTOR_BASE
  } crf_sel_t;

  typedef struct packed {
    logic valid;
    crf_op_t op;
    logic [GR_IDX_W-1:0] reg_idx;
    crf_sel_t sel;
    logic [WORD_W-1:0] wdata;
  } crf_req_t;

  typedef struct packed {
    logic take;
    logic [WORD_W-1:0] target_pc;
  } crf_exc_t;

  typedef struct packed {
    logic done;
    logic fault;
    logic [WORD_W-1:0] rdata;
  } crf_rsp_t;

endpackage : crf_pkg

// ===== design/crf_bank_map.sv
// Maps a logical general register number to its physical slot.
// Slots 0-7 hold bank 0, 8-15 bank 1, 16-23 the unbanked registers 8-15.
`timescale 1ns/1ns
`default_nettype none

module crf_bank_map (
  input wire logic [crf_pkg::GR_IDX_W-1:0] idx,
  input wire logic privileged,
  input wire logic bank_select,
  input wire logic other_bank,
  output logic [crf_pkg::PHYS_W-1:0] phys
);

  wire active_bank;

  // User mode sees bank 0 unless other_bank is set; privileged mode follows the bank select
  assign active_bank = (privileged & bank_select) ^ other_bank;
  assign phys = idx[3] ? {2'b10, idx[2:0]} : {1'b0, active_bank, idx[2:0]};

endmodule : crf_bank_map

`default_nettype wire

// ===== design/crf_gr_mem.sv
// Physical storage of the general registers: one write port and a set of
// read ports, each with registered read data.
`timescale 1ns/1ns
`default_nettype none

module crf_gr_mem #(
  parameter int unsigned DEPTH = crf_pkg::PHYS_NUM,
  parameter int unsigned ADDR_W = crf_pkg::PHYS_W,
  parameter int unsigned DATA_W = crf_pkg::WORD_W,
  parameter int unsigned NRD = 4
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [ADDR_W-1:0] raddr [NRD],
  output logic [DATA_W-1:0] rdata [NRD]
);

  logic [DATA_W-1:0] mem [DEPTH];

  if (DEPTH > (1 << ADDR_W) || NRD == 0) begin : g_check
    $error("crf_gr_mem: address too narrow or no read port");
  end

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  for (genvar i = 0; i < NRD; i++) begin : g_rd
    always_ff @(posedge sys_clk) begin
      rdata[i] <= mem[raddr[i]];
    end
  end

endmodule : crf_gr_mem

`default_nettype wire

// ===== design/crf_top.sv
// Banked register file of the processor core: general registers, system
// registers and control registers, with exception save and return.
// Assumes the decode and execute pipeline presents at most one request per
// cycle and shares sys_clk; rst covers both power-on and manual reset.
//
// Summary of operation
// - Sixteen 32-bit general registers, numbered 0-15.
// - Registers 0-7 banked twice, chosen by mode.
// - Privileged mode: bank select bit picks bank.
// - Register 0 serves as index and fixed operand.
// - System registers via load/store system classes.
// - Exception copies program counter to saved copy.
// - Exception return reloads program counter from saved.
// - System group: mac high/low, procedure return, pc.
// - Control registers accessible only in privileged mode.
// - Global base also accessible in user mode.
// - Control group: status, saved status/pc, bases.
// - Exception copies status into saved status word.
// - Unselected bank reached only by load/store bank classes.
// - Status resets: mode, bank, block, mask set.
// - Reset clears vector base, loads pc; others left undefined.
// - Reset initialisation on power-on and manual reset.
`timescale 1ns/1ns
`default_nettype none

module crf_top #(
  parameter logic [crf_pkg::WORD_W-1:0] PC_RESET_VALUE = crf_pkg::PC_RESET
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire crf_pkg::crf_req_t req,
  input wire crf_pkg::crf_exc_t exc,
  input wire logic pc_adv_en,
  input wire logic [crf_pkg::WORD_W-1:0] pc_next,
  input wire logic [crf_pkg::GR_IDX_W-1:0] rd_a_idx,
  input wire logic [crf_pkg::GR_IDX_W-1:0] rd_b_idx,
  output logic [crf_pkg::WORD_W-1:0] rd_a_data,
  output logic [crf_pkg::WORD_W-1:0] rd_b_data,
  output logic [crf_pkg::WORD_W-1:0] index_data,
  output logic [crf_pkg::WORD_W-1:0] bank_rdata,
  output crf_pkg::crf_rsp_t rsp_r,
  output logic [crf_pkg::WORD_W-1:0] status_word_r,
  output logic [crf_pkg::WORD_W-1:0] pc_r,
  output logic [crf_pkg::WORD_W-1:0] vector_base_r
);

  localparam int unsigned NRD = 4;
  localparam int unsigned RD_A = 0;
  localparam int unsigned RD_B = 1;
  localparam int unsigned RD_IDX = 2;
  localparam int unsigned RD_BANK = 3;

  if (crf_pkg::WORD_W != 32 || crf_pkg::GR_NUM != 16) begin : g_check
    $error("crf_top: register file shape not supported");
  end

  // ---------------------------------------------------------------------------
  // Registers without a defined reset value
  // ---------------------------------------------------------------------------
  logic [crf_pkg::WORD_W-1:0] mac_high_r;
  logic [crf_pkg::WORD_W-1:0] mac_low_r;
  logic [crf_pkg::WORD_W-1:0] procedure_return_r;
  logic [crf_pkg::WORD_W-1:0] saved_status_word_r;
  logic [crf_pkg::WORD_W-1:0] saved_pc_r;
  logic [crf_pkg::WORD_W-1:0] global_base_r;

  logic [crf_pkg::WORD_W-1:0] status_word_nxt;
  logic [crf_pkg::WORD_W-1:0] pc_nxt;
  crf_pkg::crf_rsp_t rsp_nxt;

  // ---------------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------------
  wire privileged;
  wire bank_select;
  wire req_live;
  wire sel_is_sys;
  wire sel_is_ctl;
  wire ctl_allowed;
  wire bank_idx_ok;
  wire do_gr_write;
  wire do_load_sys;
  wire do_store_sys;
  wire do_load_ctl;
  wire do_store_ctl;
  wire do_load_bank;
  wire do_store_bank;
  wire do_rte;
  wire req_legal;

  assign privileged = status_word_r[crf_pkg::SR_MD_POS];
  assign bank_select = status_word_r[crf_pkg::SR_RB_POS];

  // A taken exception flushes the request presented in the same cycle
  assign req_live = req.valid && !exc.take && (req.op != crf_pkg::CRF_OP_IDLE);

  assign sel_is_sys = (req.sel == crf_pkg::CRF_SEL_MAC_HIGH) ||
                      (req.sel == crf_pkg::CRF_SEL_MAC_LOW) ||
                      (req.sel == crf_pkg::CRF_SEL_PROC_RET) ||
                      (req.sel == crf_pkg::CRF_SEL_PC);
  assign sel_is_ctl = (req.sel == crf_pkg::CRF_SEL_STATUS) ||
                      (req.sel == crf_pkg::CRF_SEL_SAVED_STATUS) ||
                      (req.sel == crf_pkg::CRF_SEL_SAVED_PC) ||
                      (req.sel == crf_pkg::CRF_SEL_GLOBAL_BASE) ||
                      (req.sel == crf_pkg::CRF_SEL_VECTOR_BASE);
  assign ctl_allowed = privileged || (req.sel == crf_pkg::CRF_SEL_GLOBAL_BASE);
  assign bank_idx_ok = privileged && !req.reg_idx[3];

  assign do_gr_write = req_live && (req.op == crf_pkg::CRF_OP_GR_WRITE);
  assign do_load_sys = req_live && (req.op == crf_pkg::CRF_OP_LOAD_SYS) && sel_is_sys;
  assign do_store_sys = req_live && (req.op == crf_pkg::CRF_OP_STORE_SYS) && sel_is_sys;
  assign do_load_ctl = req_live && (req.op == crf_pkg::CRF_OP_LOAD_CTL) &&
                       sel_is_ctl && ctl_allowed;
  assign do_store_ctl = req_live && (req.op == crf_pkg::CRF_OP_STORE_CTL) &&
                        sel_is_ctl && ctl_allowed;
  assign do_load_bank = req_live && (req.op == crf_pkg::CRF_OP_LOAD_BANK) && bank_idx_ok;
  assign do_store_bank = req_live && (req.op == crf_pkg::CRF_OP_STORE_BANK) && bank_idx_ok;
  assign do_rte = req_live && (req.op == crf_pkg::CRF_OP_RETURN_EXC) && privileged;

  assign req_legal = do_gr_write || do_load_sys || do_store_sys || do_load_ctl ||
                     do_store_ctl || do_load_bank || do_store_bank || do_rte;

  // ---------------------------------------------------------------------------
  // General register storage and bank mapping
  // ---------------------------------------------------------------------------
  logic [crf_pkg::PHYS_W-1:0] raddr [NRD];
  logic [crf_pkg::WORD_W-1:0] rdata [NRD];
  logic [crf_pkg::PHYS_W-1:0] wr_phys;
  logic [crf_pkg::PHYS_W-1:0] wr_alt_phys;
  wire [crf_pkg::PHYS_W-1:0] mem_waddr;
  wire mem_we;

  crf_bank_map u_map_a (
    .idx(rd_a_idx),
    .privileged(privileged),
    .bank_select(bank_select),
    .other_bank(1'b0),
    .phys(raddr[RD_A])
  );

  crf_bank_map u_map_b (
    .idx(rd_b_idx),
    .privileged(privileged),
    .bank_select(bank_select),
    .other_bank(1'b0),
    .phys(raddr[RD_B])
  );

  // Register 0 of the active bank feeds the indexed addressing modes
  crf_bank_map u_map_idx (
    .idx(crf_pkg::INDEX_REG),
    .privileged(privileged),
    .bank_select(bank_select),
    .other_bank(1'b0),
    .phys(raddr[RD_IDX])
  );

  // The bank that ordinary references do not reach
  crf_bank_map u_map_bank (
    .idx(req.reg_idx),
    .privileged(privileged),
    .bank_select(bank_select),
    .other_bank(1'b1),
    .phys(raddr[RD_BANK])
  );

  crf_bank_map u_map_wr (
    .idx(req.reg_idx),
    .privileged(privileged),
    .bank_select(bank_select),
    .other_bank(1'b0),
    .phys(wr_phys)
  );

  assign wr_alt_phys = raddr[RD_BANK];
  assign mem_we = do_gr_write || do_load_bank;
  assign mem_waddr = do_load_bank ? wr_alt_phys : wr_phys;

  crf_gr_mem #(
    .DEPTH(crf_pkg::PHYS_NUM),
    .ADDR_W(crf_pkg::PHYS_W),
    .DATA_W(crf_pkg::WORD_W),
    .NRD(NRD)
  ) u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(req.wdata),
    .raddr(raddr),
    .rdata(rdata)
  );

  assign rd_a_data = rdata[RD_A];
  assign rd_b_data = rdata[RD_B];
  assign index_data = rdata[RD_IDX];
  assign bank_rdata = rdata[RD_BANK];

  // ---------------------------------------------------------------------------
  // Status word and program counter
  // ---------------------------------------------------------------------------
  wire ld_status;
  wire ld_pc;

  assign ld_status = do_load_ctl && (req.sel == crf_pkg::CRF_SEL_STATUS);
  assign ld_pc = do_load_sys && (req.sel == crf_pkg::CRF_SEL_PC);

  // Return restores the saved status along with the saved program counter
  assign status_word_nxt = do_rte ? (saved_status_word_r & crf_pkg::SR_WRITE_MASK) :
                           ld_status ? (req.wdata & crf_pkg::SR_WRITE_MASK) :
                           status_word_r;
  assign pc_nxt = exc.take ? exc.target_pc :
                  do_rte ? saved_pc_r :
                  ld_pc ? req.wdata :
                  pc_adv_en ? pc_next :
                  pc_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_word_r <= crf_pkg::SR_RESET;
      pc_r <= PC_RESET_VALUE;
      vector_base_r <= crf_pkg::VBR_RESET;
    end else begin
      status_word_r <= status_word_nxt;
      pc_r <= pc_nxt;
      if (do_load_ctl && req.sel == crf_pkg::CRF_SEL_VECTOR_BASE) begin
        vector_base_r <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Exception save state and saved copies
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (exc.take) begin
      saved_pc_r <= pc_r;
      saved_status_word_r <= status_word_r;
    end else begin
      if (do_load_ctl && req.sel == crf_pkg::CRF_SEL_SAVED_PC) begin
        saved_pc_r <= req.wdata;
      end
      if (do_load_ctl && req.sel == crf_pkg::CRF_SEL_SAVED_STATUS) begin
        saved_status_word_r <= req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // System registers and global base
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (do_load_sys && req.sel == crf_pkg::CRF_SEL_MAC_HIGH) begin
      mac_high_r <= req.wdata;
    end
    if (do_load_sys && req.sel == crf_pkg::CRF_SEL_MAC_LOW) begin
      mac_low_r <= req.wdata;
    end
    if (do_load_sys && req.sel == crf_pkg::CRF_SEL_PROC_RET) begin
      procedure_return_r <= req.wdata;
    end
    if (do_load_ctl && req.sel == crf_pkg::CRF_SEL_GLOBAL_BASE) begin
      global_base_r <= req.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Store read-back and response
  // ---------------------------------------------------------------------------
  logic [crf_pkg::WORD_W-1:0] sel_rdata;

  always_comb begin
    sel_rdata = '0;
    unique case (req.sel)
      crf_pkg::CRF_SEL_MAC_HIGH: sel_rdata = mac_high_r;
      crf_pkg::CRF_SEL_MAC_LOW: sel_rdata = mac_low_r;
      crf_pkg::CRF_SEL_PROC_RET: sel_rdata = procedure_return_r;
      crf_pkg::CRF_SEL_PC: sel_rdata = pc_r;
      crf_pkg::CRF_SEL_STATUS: sel_rdata = status_word_r;
      crf_pkg::CRF_SEL_SAVED_STATUS: sel_rdata = saved_status_word_r;
      crf_pkg::CRF_SEL_SAVED_PC: sel_rdata = saved_pc_r;
      crf_pkg::CRF_SEL_GLOBAL_BASE: sel_rdata = global_base_r;
      crf_pkg::CRF_SEL_VECTOR_BASE: sel_rdata = vector_base_r;
      default: sel_rdata = '0;
    endcase
  end

  // Refused accesses report a fault and change no register
  assign rsp_nxt.done = req_live;
  assign rsp_nxt.fault = req_live && !req_legal;
  assign rsp_nxt.rdata = (do_store_sys || do_store_ctl) ? sel_rdata : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

endmodule : crf_top

`default_nettype wire

// ===== bench/crf_top_asserts.sv
// Checker bound to crf_top: reset values, response pulses, access faults
// and program counter moves. Sees only the ports of crf_top.
`timescale 1ns/1ns
`default_nettype none

module crf_top_asserts #(
  parameter logic [31:0] PC_RESET_VALUE = crf_pkg::PC_RESET
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire crf_pkg::crf_req_t req,
  input wire crf_pkg::crf_exc_t exc,
  input wire crf_pkg::crf_rsp_t rsp_r,
  input wire logic [31:0] status_word_r,
  input wire logic [31:0] pc_r,
  input wire logic [31:0] vector_base_r
);
  wire logic tk = req.valid && req.op != crf_pkg::CRF_OP_IDLE && !exc.take;
  wire logic md = status_word_r[crf_pkg::SR_MD_POS];
  wire logic ctl = req.op == crf_pkg::CRF_OP_LOAD_CTL || req.op == crf_pkg::CRF_OP_STORE_CTL;
  wire logic sys = req.op == crf_pkg::CRF_OP_LOAD_SYS || req.op == crf_pkg::CRF_OP_STORE_SYS;
  wire logic bnk = req.op == crf_pkg::CRF_OP_LOAD_BANK || req.op == crf_pkg::CRF_OP_STORE_BANK;
  wire logic gb = req.sel == crf_pkg::CRF_SEL_GLOBAL_BASE;
  wire logic return_from_exception_instr = req.op == crf_pkg::CRF_OP_RETURN_EXC;
  wire logic sr_wr = tk && (return_from_exception_instr || req.op == crf_pkg::CRF_OP_LOAD_CTL
    && req.sel == crf_pkg::CRF_SEL_STATUS);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_reset_status: assert property ($fell(rst) |-> status_word_r == 32'h7000_00f0)
    else $error("status word wrong after reset");
  a_reset_vbr: assert property ($fell(rst) |-> vector_base_r == '0 && rsp_r == '0)
    else $error("vector base or response wrong after reset");
  a_reset_pc: assert property ($fell(rst) |-> pc_r == PC_RESET_VALUE)
    else $error("program counter wrong after reset");
  a_done_pulse: assert property (tk |=> rsp_r.done)
    else $error("taken request gave no done");
  a_exc_pc: assert property (exc.take |=> pc_r == $past(exc.target_pc))
    else $error("exception did not load the program counter");
  a_sys_sel: assert property (tk && sys && req.sel > crf_pkg::CRF_SEL_PC |=> rsp_r.fault)
    else $error("system access to a control register not refused");
  a_user_ctl: assert property (tk && ctl && !md && !gb |=> rsp_r.fault)
    else $error("user control access not refused");
  a_user_gbr: assert property (tk && ctl && gb |=> !rsp_r.fault)
    else $error("global base access refused");
  a_vbr_load: assert property (tk && md && ctl && req.op == crf_pkg::CRF_OP_LOAD_CTL
    && req.sel == crf_pkg::CRF_SEL_VECTOR_BASE |=> vector_base_r == $past(req.wdata))
    else $error("vector base not loaded");
  a_bank_fault: assert property (tk && bnk && (!md || req.reg_idx[3]) |=> rsp_r.fault)
    else $error("bad bank access not refused");
  a_rte_user: assert property (tk && !md && return_from_exception_instr |=> rsp_r.fault)
    else $error("user return not refused");
  a_status_quiet: assert property (!sr_wr |=> $stable(status_word_r))
    else $error("status word changed without a write");

  c_return: cover property (tk && md && return_from_exception_instr);
  c_exc: cover property (exc.take);
  c_bank: cover property (tk && bnk && md);
endmodule : crf_top_asserts

bind crf_top crf_top_asserts #(.PC_RESET_VALUE(PC_RESET_VALUE)) i_chk (.sys_clk(sys_clk),
  .rst(rst), .req(req), .exc(exc), .rsp_r(rsp_r), .status_word_r(status_word_r),
  .pc_r(pc_r), .vector_base_r(vector_base_r));
`default_nettype wire

// ===== bench/crf_pipe_model.sv
// Model of the decode and execute pipeline that drives crf_top.
// Assumes callers enter each task at a falling edge of sys_clk.
`timescale 1ns/1ns
`default_nettype none

module crf_pipe_model (
  input wire logic sys_clk,
  input wire crf_pkg::crf_rsp_t rsp_r,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  output var crf_pkg::crf_req_t req,
  output var crf_pkg::crf_exc_t exc,
  output logic pc_adv_en,
  output logic [31:0] pc_next,
  output logic [3:0] rd_a_idx,
  output logic [3:0] rd_b_idx
);
  initial begin
    req = '0;
    exc = '0;
    pc_adv_en = 1'b0;
    pc_next = 32'h0;
    rd_a_idx = 4'h0;
    rd_b_idx = 4'h0;
  end

  // Request stands for one edge, then drops with its data scrambled
  task automatic issue(input crf_pkg::crf_op_t op, input logic [3:0] idx,
      input crf_pkg::crf_sel_t sel, input logic [31:0] wd, output crf_pkg::crf_rsp_t rsp);
    req = '{1'b1, op, idx, sel, wd};
    @(negedge sys_clk);
    rsp = rsp_r;
    req = '{1'b0, op, idx, sel, ~wd};
    @(negedge sys_clk);
  endtask : issue

  task automatic step(input logic take, input logic adv, input logic [31:0] pc);
    exc = '{take, pc};
    pc_adv_en = adv;
    pc_next = take ? ~pc : pc;
    @(negedge sys_clk);
    exc = '{1'b0, ~pc};
    pc_adv_en = 1'b0;
    @(negedge sys_clk);
  endtask : step

  task automatic read(input logic [3:0] a, input logic [3:0] b, output logic [31:0] da,
      output logic [31:0] db);
    rd_a_idx = a;
    rd_b_idx = b;
    @(negedge sys_clk);
    da = rd_a_data;
    db = rd_b_data;
  endtask : read
endmodule : crf_pipe_model
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench for crf_top: banking, system and control access, exception
// save and return, user-mode limits and reset values.
// Assumes crf_pipe_model drives every pipeline input of the block.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  crf_pkg::crf_req_t req;
  crf_pkg::crf_exc_t exc;
  crf_pkg::crf_rsp_t rsp_r;
  crf_pkg::crf_rsp_t rsp;
  logic pc_adv_en;
  logic [3:0] rd_a_idx;
  logic [3:0] rd_b_idx;
  logic [31:0] pc_next, rd_a_data, rd_b_data, index_data, bank_rdata;
  logic [31:0] status_word_r, pc_r, vector_base_r, rda, rdb;
  int checked = 0;
  int miscompares = 0;

  always #4 sys_clk = ~sys_clk;

  crf_top i_dut (.sys_clk(sys_clk), .rst(rst), .req(req), .exc(exc), .pc_adv_en(pc_adv_en),
    .pc_next(pc_next), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .index_data(index_data), .bank_rdata(bank_rdata), .rsp_r(rsp_r),
    .status_word_r(status_word_r), .pc_r(pc_r), .vector_base_r(vector_base_r));
  crf_pipe_model i_pipe (.sys_clk(sys_clk), .rsp_r(rsp_r), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data), .req(req), .exc(exc), .pc_adv_en(pc_adv_en), .pc_next(pc_next),
    .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx));

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask : check_flag

  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    check_word("status", 32'h7000_00f0, status_word_r);
    check_word("vector base", 32'h0000_0000, vector_base_r);
    check_word("pc", 32'h0a00_0000, pc_r);
  endtask : t_reset

  task automatic t_banks;
    i_pipe.issue(crf_pkg::CRF_OP_GR_WRITE, 4'h3, crf_pkg::CRF_SEL_PC, 32'h1111_0003, rsp);
    i_pipe.issue(crf_pkg::CRF_OP_GR_WRITE, 4'h0, crf_pkg::CRF_SEL_PC, 32'h1111_0000, rsp);
    i_pipe.issue(crf_pkg::CRF_OP_GR_WRITE, 4'h8, crf_pkg::CRF_SEL_PC, 32'h8888_0008, rsp);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_BANK, 4'h3, crf_pkg::CRF_SEL_PC, 32'h0000_bbb3, rsp);
    i_pipe.read(4'h3, 4'h8, rda, rdb);
    check_word("gr3 bank one", 32'h1111_0003, rda);
    check_word("gr8", 32'h8888_0008, rdb);
    check_word("index register", 32'h1111_0000, index_data);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_BANK, 4'h3, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_word("other bank gr3", 32'h0000_bbb3, bank_rdata);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_CTL, 4'h0, crf_pkg::CRF_SEL_STATUS, 32'h5000_00f0, rsp);
    check_word("status", 32'h5000_00f0, status_word_r);
    i_pipe.read(4'h3, 4'h8, rda, rdb);
    check_word("gr3 bank zero", 32'h0000_bbb3, rda);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_BANK, 4'h3, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_word("other bank gr3", 32'h1111_0003, bank_rdata);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_BANK, 4'h9, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_flag("bank index fault", 1'b1, rsp.fault);
  endtask : t_banks

  // Selects 0-3 are system registers, 5-8 control registers other than status
  task automatic t_regs(input crf_pkg::crf_op_t ld, input crf_pkg::crf_op_t st, input int lo);
    for (int k = lo; k < lo + 4; k++) begin
      if (k != 3) begin
        i_pipe.issue(ld, 4'h0, crf_pkg::crf_sel_t'(k), 32'h5a5a_0000 | 32'(k), rsp);
        i_pipe.issue(st, 4'h0, crf_pkg::crf_sel_t'(k), 32'h0, rsp);
        check_word("register readback", 32'h5a5a_0000 | 32'(k), rsp.rdata);
      end
    end
    i_pipe.issue(ld, 4'h0, crf_pkg::crf_sel_t'(8 - lo), 32'h0, rsp);
    check_flag("wrong group fault", 1'b1, rsp.fault);
  endtask : t_regs

  task automatic t_exception;
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_SYS, 4'h0, crf_pkg::CRF_SEL_PC, 32'h0000_1000, rsp);
    check_word("pc load", 32'h0000_1000, pc_r);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_SYS, 4'h0, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_word("pc readback", 32'h0000_1000, rsp.rdata);
    i_pipe.step(1'b0, 1'b1, 32'h0000_2000);
    check_word("pc advance", 32'h0000_2000, pc_r);
    i_pipe.step(1'b1, 1'b1, 32'h0000_0600);
    check_word("pc on exception", 32'h0000_0600, pc_r);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_CTL, 4'h0, crf_pkg::CRF_SEL_SAVED_PC, 32'h0, rsp);
    check_word("saved pc", 32'h0000_2000, rsp.rdata);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_CTL, 4'h0, crf_pkg::CRF_SEL_SAVED_STATUS, 32'h0, rsp);
    check_word("saved status", 32'h5000_00f0, rsp.rdata);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_CTL, 4'h0, crf_pkg::CRF_SEL_STATUS, 32'h4000_0000, rsp);
    i_pipe.issue(crf_pkg::CRF_OP_RETURN_EXC, 4'h0, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_word("pc on return", 32'h0000_2000, pc_r);
    check_word("status on return", 32'h5000_00f0, status_word_r);
  endtask : t_exception

  task automatic t_user;
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_CTL, 4'h0, crf_pkg::CRF_SEL_STATUS, 32'h2000_00f0, rsp);
    i_pipe.read(4'h3, 4'h8, rda, rdb);
    check_word("user gr3", 32'h0000_bbb3, rda);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_CTL, 4'h0, crf_pkg::CRF_SEL_VECTOR_BASE, 32'h0, rsp);
    check_flag("user control fault", 1'b1, rsp.fault);
    check_word("vector base kept", 32'h5a5a_0008, vector_base_r);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_CTL, 4'h0, crf_pkg::CRF_SEL_GLOBAL_BASE, 32'h6060_0606, rsp);
    i_pipe.issue(crf_pkg::CRF_OP_STORE_CTL, 4'h0, crf_pkg::CRF_SEL_GLOBAL_BASE, 32'h0, rsp);
    check_word("user global base", 32'h6060_0606, rsp.rdata);
    i_pipe.issue(crf_pkg::CRF_OP_RETURN_EXC, 4'h0, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_flag("user return fault", 1'b1, rsp.fault);
    i_pipe.issue(crf_pkg::CRF_OP_LOAD_BANK, 4'h3, crf_pkg::CRF_SEL_PC, 32'h0, rsp);
    check_flag("user bank fault", 1'b1, rsp.fault);
  endtask : t_user

  initial begin
    @(negedge sys_clk);
    t_reset();
    t_banks();
    t_regs(crf_pkg::CRF_OP_LOAD_SYS, crf_pkg::CRF_OP_STORE_SYS, 0);
    t_regs(crf_pkg::CRF_OP_LOAD_CTL, crf_pkg::CRF_OP_STORE_CTL, 5);
    t_exception();
    t_user();
    t_reset();
    complete_run();
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
